/* pkg/ubf_pkg.sv */
`default_nettype none
package ubf_pkg;
	localparam int          DIV_W         = 12;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_DIV_LOW  = 8'h00;
	localparam logic [7:0]  ADDR_DIV_HIGH = 8'h04;
	localparam logic [7:0]  ADDR_CTRL     = 8'h08;
	localparam logic [7:0]  ADDR_TX_DATA  = 8'h0c;
	localparam logic [7:0]  ADDR_RX_DATA  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS   = 8'h14;
	localparam logic [11:0] CTRL_RESET    = 12'h180;
	localparam logic [11:0] DIV_RESET     = 12'h000;
	localparam logic [4:0]  SPB_NORMAL    = 5'h10;
	localparam logic [4:0]  SPB_DOUBLE    = 5'h08;
	localparam logic [4:0]  SPB_SYNC      = 5'h02;
	localparam logic [2:0]  CSZ_NINE      = 3'h7;
	localparam logic [3:0]  CSZ_BASE      = 4'h5;
	localparam logic [3:0]  MAX_BITS      = 4'h9;
	localparam logic [1:0]  PAR_ODD       = 2'h3;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_START,
		PH_DATA,
		PH_PAR,
		PH_STOP
	} ubf_phase_e;

	// Bit 0 is syncMode, upward in declaration order reversed
	typedef struct packed {
		logic       rxEnable;
		logic       txEnable;
		logic [2:0] charSize;
		logic [1:0] parityMode;
		logic       twoStop;
		logic       clockPolarity;
		logic       doubleSpeed;
		logic       masterClk;
		logic       syncMode;
	} ubf_ctrl_s;
endpackage
`default_nettype wire

/* pkg/ubf_clk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ubf_clk_if;
	logic [ubf_pkg::DIV_W-1:0] divisor;
	logic                      reload;
	logic                      tick;
	modport gen (input divisor, input reload, output tick);
	modport core (output divisor, output reload, input tick);
endinterface
`default_nettype wire

/* logic/ubf_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ubf_baud_gen (
	input wire logic clock,
	input wire logic rstN,
	ubf_clk_if.gen   bus
);
	typedef struct packed {
		logic [ubf_pkg::DIV_W-1:0] count;
		logic                      tick;
	} ubf_bg_s;

	ubf_bg_s st;
	ubf_bg_s next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (bus.reload) begin
			next_st.count = bus.divisor;
		end else if (st.count == '0) begin
			next_st.count = bus.divisor;
			next_st.tick = 1'b1;
		end else begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign bus.tick = st.tick;

	a_reload_hold: assert property (@(posedge clock) disable iff (!rstN)
		bus.reload |=> (!st.tick && st.count == $past(bus.divisor)))
		else $error("reload did not restart the counter");
	a_tick_period: assert property (@(posedge clock) disable iff (!rstN)
		(st.count == '0 && !bus.reload) |=> (st.tick && st.count == $past(bus.divisor)))
		else $error("no tick or bad reload at zero");
endmodule
`default_nettype wire

/* logic/ubf_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ubf_edge_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clock,
	input  wire logic rstN,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} ubf_es_s;

	ubf_es_s st;
	ubf_es_s next_st;

	always_comb begin
		next_st.meta = pinIn;
		next_st.stable = st.meta;
		next_st.prev = st.stable;
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			st <= {INIT, INIT, INIT};
		end else begin
			st <= next_st;
		end
	end

	// Meta flop feeds only the stable flop
	assign level = st.stable;
	assign rise = st.stable & ~st.prev;
	assign fall = ~st.stable & st.prev;
endmodule
`default_nettype wire

/* logic/ubf_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ubf_top (
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	input  wire logic [ubf_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ubf_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        serialInPin,
	output logic                             serialOutPin,
	input  wire logic                        xferClockIn,
	output logic                             xferClockOut,
	output logic                             xferClockOe
);
	typedef struct packed {
		ubf_pkg::ubf_ctrl_s        ctrl;
		logic [ubf_pkg::DIV_W-1:0] divisor;
		logic                      awHave;
		logic [7:0]                awAddr;
		logic                      wHave;
		logic [31:0]               wData;
		logic [3:0]                wStrb;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
		logic                      xckInt;
		ubf_pkg::ubf_phase_e       txPh;
		logic [4:0]                txTicks;
		logic [3:0]                txBit;
		logic [8:0]                txShift;
		logic                      txParity;
		logic                      txStop;
		logic                      txOut;
		logic                      txComplete;
		ubf_pkg::ubf_phase_e       rxPh;
		logic [4:0]                rxTicks;
		logic [3:0]                rxBit;
		logic [8:0]                rxShift;
		logic                      rxParity;
		logic [8:0]                rxData;
		logic                      rxFrameErr;
		logic                      rxParErr;
		logic                      rxValid;
	} ubf_top_s;

	logic [1:0]  rstSync;
	logic        rstN;
	ubf_top_s    st;
	ubf_top_s    next_st;
	logic        tick;
	logic        rxLevel;
	logic        rxFall;
	logic        xckRiseS;
	logic        xckFallS;
	logic        master;
	logic        clkRise;
	logic        clkFall;
	logic        changeEdge;
	logic        sampleEdge;
	logic [4:0]  spb;
	logic [4:0]  rxLimit;
	logic [3:0]  nBits;
	logic        parOn;
	logic        txBusy;
	logic        txStep;
	logic        rxSample;
	logic        doWrite;
	logic        reload;
	logic [31:0] wMerged;
	logic [8:0]  aligned;

	ubf_clk_if clkIf ();

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	ubf_baud_gen u_baud (
		.clock (clock),
		.rstN  (rstN),
		.bus   (clkIf.gen)
	);

	ubf_edge_sync #(.INIT(1'b1)) u_rx_sync (
		.clock (clock),
		.rstN  (rstN),
		.pinIn (serialInPin),
		.level (rxLevel),
		.rise  (),
		.fall  (rxFall)
	);

	ubf_edge_sync #(.INIT(1'b0)) u_xck_sync (
		.clock (clock),
		.rstN  (rstN),
		.pinIn (xferClockIn),
		.level (),
		.rise  (xckRiseS),
		.fall  (xckFallS)
	);

	function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n,
			input logic [1:0] mode);
		logic [8:0] mask;
		mask = 9'h1ff >> (ubf_pkg::MAX_BITS - n);
		return (^(d & mask)) ^ (mode == ubf_pkg::PAR_ODD);
	endfunction

	function automatic logic isMapped(input logic [7:0] a);
		case (a)
			ubf_pkg::ADDR_DIV_LOW,
			ubf_pkg::ADDR_DIV_HIGH,
			ubf_pkg::ADDR_CTRL,
			ubf_pkg::ADDR_TX_DATA,
			ubf_pkg::ADDR_RX_DATA,
			ubf_pkg::ADDR_STATUS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] readReg(input logic [7:0] a);
		case (a)
			ubf_pkg::ADDR_DIV_LOW: return {24'h0, st.divisor[7:0]};
			ubf_pkg::ADDR_DIV_HIGH: return {28'h0, st.divisor[11:8]};
			ubf_pkg::ADDR_CTRL: return {20'h0, st.ctrl};
			ubf_pkg::ADDR_RX_DATA: return {21'h0, st.rxParErr, st.rxFrameErr, st.rxData};
			ubf_pkg::ADDR_STATUS: return {29'h0, st.rxValid, st.txComplete, txBusy};
			default: return 32'h0;
		endcase
	endfunction

	assign spb = st.ctrl.syncMode ? ubf_pkg::SPB_SYNC :
		(st.ctrl.doubleSpeed ? ubf_pkg::SPB_DOUBLE : ubf_pkg::SPB_NORMAL);
	assign nBits = (st.ctrl.charSize == ubf_pkg::CSZ_NINE) ? ubf_pkg::MAX_BITS :
		({2'h0, st.ctrl.charSize[1:0]} + ubf_pkg::CSZ_BASE);
	assign parOn = st.ctrl.parityMode[1];
	assign tick = clkIf.tick;
	assign txBusy = (st.txPh != ubf_pkg::PH_IDLE);

	assign master = st.ctrl.syncMode & st.ctrl.masterClk;
	assign clkRise = master ? (tick & ~st.xckInt) : xckRiseS;
	assign clkFall = master ? (tick & st.xckInt) : xckFallS;
	assign changeEdge = st.ctrl.clockPolarity ? clkFall : clkRise;
	assign sampleEdge = st.ctrl.clockPolarity ? clkRise : clkFall;

	assign txStep = st.ctrl.syncMode ? changeEdge : (tick && st.txTicks == spb - 5'h01);
	// Mid-bit for the start, full bit afterwards
	assign rxLimit = (st.rxPh == ubf_pkg::PH_START) ? ((spb >> 1) - 5'h01) : (spb - 5'h01);
	assign rxSample = st.ctrl.syncMode ? sampleEdge : (tick && st.rxTicks == rxLimit);

	assign wMerged = st.wData & {{8{st.wStrb[3]}}, {8{st.wStrb[2]}},
		{8{st.wStrb[1]}}, {8{st.wStrb[0]}}};
	assign aligned = st.rxShift >> (ubf_pkg::MAX_BITS - nBits);

	always_comb begin
		next_st = st;
		doWrite = 1'b0;
		reload = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.awHave = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.wHave = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awHave && st.wHave && !st.bvalid) begin
			next_st.awHave = 1'b0;
			next_st.wHave = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = isMapped(st.awAddr) ? ubf_pkg::RESP_OKAY : ubf_pkg::RESP_SLVERR;
			doWrite = 1'b1;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = readReg(s_axi_araddr);
			next_st.rresp = isMapped(s_axi_araddr) ? ubf_pkg::RESP_OKAY : ubf_pkg::RESP_SLVERR;
			// Clears first so a same-cycle set wins below
			if (s_axi_araddr == ubf_pkg::ADDR_RX_DATA) begin
				next_st.rxValid = 1'b0;
			end
		end
		if (doWrite) begin
			case (st.awAddr)
				ubf_pkg::ADDR_DIV_LOW: begin
					if (st.wStrb[0]) begin
						next_st.divisor[7:0] = st.wData[7:0];
					end
					reload = 1'b1;
				end
				ubf_pkg::ADDR_DIV_HIGH: begin
					if (st.wStrb[0]) begin
						next_st.divisor[11:8] = st.wData[3:0];
					end
				end
				ubf_pkg::ADDR_CTRL: begin
					next_st.ctrl = ubf_pkg::ubf_ctrl_s'((st.ctrl & ~{{4{st.wStrb[1]}},
						{8{st.wStrb[0]}}}) | wMerged[11:0]);
				end
				ubf_pkg::ADDR_TX_DATA: begin
					// Writes while busy or disabled are dropped
					if (!txBusy && st.ctrl.txEnable) begin
						next_st.txShift = st.wData[8:0];
						next_st.txParity = parityOf(st.wData[8:0], nBits, st.ctrl.parityMode);
						next_st.txPh = ubf_pkg::PH_START;
						next_st.txTicks = 5'h00;
						next_st.txStop = 1'b0;
						next_st.txOut = 1'b0;
					end
				end
				ubf_pkg::ADDR_STATUS: begin
					if (st.wStrb[0] && st.wData[1]) begin
						next_st.txComplete = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// master clock is tick over two
		if (master && tick) begin
			next_st.xckInt = ~st.xckInt;
		end else if (!master) begin
			next_st.xckInt = 1'b0;
		end

		if (txBusy && !st.ctrl.syncMode && tick) begin
			next_st.txTicks = txStep ? 5'h00 : st.txTicks + 5'h01;
		end
		if (txBusy && txStep) begin
			case (st.txPh)
				ubf_pkg::PH_START: begin
					next_st.txPh = ubf_pkg::PH_DATA;
					next_st.txOut = st.txShift[0];
					next_st.txShift = st.txShift >> 1;
					next_st.txBit = 4'h1;
				end
				ubf_pkg::PH_DATA: begin
					if (st.txBit == nBits) begin
						next_st.txPh = parOn ? ubf_pkg::PH_PAR : ubf_pkg::PH_STOP;
						next_st.txOut = parOn ? st.txParity : 1'b1;
					end else begin
						next_st.txOut = st.txShift[0];
						next_st.txShift = st.txShift >> 1;
						next_st.txBit = st.txBit + 4'h1;
					end
				end
				ubf_pkg::PH_PAR: begin
					next_st.txPh = ubf_pkg::PH_STOP;
					next_st.txOut = 1'b1;
				end
				ubf_pkg::PH_STOP: begin
					if (st.ctrl.twoStop && !st.txStop) begin
						next_st.txStop = 1'b1;
					end else begin
						next_st.txPh = ubf_pkg::PH_IDLE;
						next_st.txComplete = 1'b1;
					end
				end
				default: begin
					next_st.txPh = ubf_pkg::PH_IDLE;
				end
			endcase
		end
		if (next_st.txPh == ubf_pkg::PH_IDLE) begin
			next_st.txOut = 1'b1;
		end

		if (st.rxPh != ubf_pkg::PH_IDLE && !st.ctrl.syncMode && tick) begin
			next_st.rxTicks = rxSample ? 5'h00 : st.rxTicks + 5'h01;
		end
		case (st.rxPh)
			ubf_pkg::PH_IDLE: begin
				if (st.ctrl.rxEnable && !st.ctrl.syncMode && rxFall) begin
					next_st.rxPh = ubf_pkg::PH_START;
					next_st.rxTicks = 5'h00;
				end else if (st.ctrl.rxEnable && st.ctrl.syncMode && sampleEdge && !rxLevel) begin
					next_st.rxPh = ubf_pkg::PH_DATA;
					next_st.rxBit = 4'h0;
				end
			end
			ubf_pkg::PH_START: begin
				// A start that is gone by mid-bit is noise
				if (rxSample) begin
					next_st.rxPh = rxLevel ? ubf_pkg::PH_IDLE : ubf_pkg::PH_DATA;
					next_st.rxBit = 4'h0;
				end
			end
			ubf_pkg::PH_DATA: begin
				if (rxSample) begin
					next_st.rxShift = {rxLevel, st.rxShift[8:1]};
					next_st.rxBit = st.rxBit + 4'h1;
					if (st.rxBit == nBits - 4'h1) begin
						next_st.rxPh = parOn ? ubf_pkg::PH_PAR : ubf_pkg::PH_STOP;
					end
				end
			end
			ubf_pkg::PH_PAR: begin
				if (rxSample) begin
					next_st.rxParity = rxLevel;
					next_st.rxPh = ubf_pkg::PH_STOP;
				end
			end
			ubf_pkg::PH_STOP: begin
				if (rxSample) begin
					next_st.rxFrameErr = !rxLevel;
					next_st.rxData = aligned;
					next_st.rxParErr = parOn &&
						(parityOf(aligned, nBits, st.ctrl.parityMode) != st.rxParity);
					next_st.rxValid = 1'b1;
					next_st.rxPh = ubf_pkg::PH_IDLE;
				end
			end
			default: begin
				next_st.rxPh = ubf_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			st <= '0;
			st.ctrl <= ubf_pkg::CTRL_RESET;
			st.divisor <= ubf_pkg::DIV_RESET;
			st.txOut <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign clkIf.divisor = next_st.divisor;
	assign clkIf.reload = reload;

	assign s_axi_awready = !st.awHave && !st.bvalid;
	assign s_axi_wready = !st.wHave && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign serialOutPin = st.txOut;
	assign xferClockOut = st.xckInt;
	assign xferClockOe = master;

	a_idle_high: assert property (@(posedge clock) disable iff (!rstN)
		(st.txPh == ubf_pkg::PH_IDLE) |-> serialOutPin)
		else $error("idle line not high");
	a_start_low: assert property (@(posedge clock) disable iff (!rstN)
		(st.txPh == ubf_pkg::PH_START) |-> !serialOutPin)
		else $error("start bit not low");
	a_lsb_first: assert property (@(posedge clock) disable iff (!rstN)
		(st.txPh == ubf_pkg::PH_START && txStep) |=> (serialOutPin == $past(st.txShift[0])))
		else $error("first data bit is not the LSB");
	a_parity_slot: assert property (@(posedge clock) disable iff (!rstN)
		(st.txPh == ubf_pkg::PH_PAR) |-> (serialOutPin == st.txParity))
		else $error("parity slot carries wrong value");
	a_master_clock: assert property (@(posedge clock) disable iff (!rstN)
		(master && $past(master) && $past(tick)) |-> (xferClockOut != $past(xferClockOut)))
		else $error("master clock did not toggle on tick");
	a_sync_change: assert property (@(posedge clock) disable iff (!rstN)
		(st.ctrl.syncMode && $past(st.txPh) != ubf_pkg::PH_IDLE && $changed(serialOutPin))
		|-> $past(changeEdge))
		else $error("sync data changed off its edge");
	a_frame_check: assert property (@(posedge clock) disable iff (!rstN)
		(st.rxPh == ubf_pkg::PH_STOP && rxSample) |=> (st.rxFrameErr == !$past(rxLevel)))
		else $error("frame error not from first stop bit");
	a_clock_dir: assert property (@(posedge clock) disable iff (!rstN)
		!st.ctrl.syncMode |-> (!xferClockOe ##1 !xferClockOe || st.ctrl.syncMode))
		else $error("clock pin driven outside sync master");

	c_tx_done: cover property (@(posedge clock) disable iff (!rstN)
		st.txPh == ubf_pkg::PH_STOP ##1 st.txPh == ubf_pkg::PH_IDLE);
	c_rx_done: cover property (@(posedge clock) disable iff (!rstN) $rose(st.rxValid));
	c_frame_err: cover property (@(posedge clock) disable iff (!rstN) $rose(st.rxFrameErr));
	c_sync_tx: cover property (@(posedge clock) disable iff (!rstN)
		master && st.txPh == ubf_pkg::PH_DATA);
endmodule
`default_nettype wire

/* bench/ubf_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module ubf_remote (
	input  wire logic clock,
	input  wire logic lineIn,
	output logic      lineOut
);
	initial lineOut = 1'b1;
	task automatic rx_frame(input int bitClk, input int n, output logic [15:0] bits,
		output logic lost);
		int k;
		bits = '1;
		for (k = 0; k < 8000 && lineIn === 1'b1; k++) begin
			@(posedge clock);
		end
		lost = (k == 8000);
		// Half a bit in, so a one-clock start offset is harmless
		repeat (bitClk / 2) @(posedge clock);
		for (k = 0; k < n; k++) begin
			bits[k] = lineIn;
			repeat (bitClk) @(posedge clock);
		end
	endtask
	task automatic tx_frame(input int bitClk, input int n, input logic [15:0] bits);
		int k;
		for (k = 0; k < n; k++) begin
			lineOut <= bits[k];
			repeat (bitClk) @(posedge clock);
		end
		lineOut <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic        awValid = 1'b0;
	logic        wValid = 1'b0;
	logic        bReady = 1'b0;
	logic        arValid = 1'b0;
	logic        rReady = 1'b0;
	logic        xClkIn = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [1:0]  bResp, rResp, resp;
	logic [31:0] rData, rv;
	logic        txLine, rxLine, xClkOut, xClkOe, lost;
	logic [15:0] bits;
	int          err_total = 0;
	int          cmp_count = 0;
	always #10 clock = ~clock;
	ubf_top DUT (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .serialInPin(rxLine), .serialOutPin(txLine),
		.xferClockIn(xClkIn), .xferClockOut(xClkOut), .xferClockOe(xClkOe));
	ubf_remote peer (.clock(clock), .lineIn(txLine), .lineOut(rxLine));
	task automatic complete_run();
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		err_total++;
		complete_run();
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (k = 0; k < 50 && bValid !== 1'b1; k++) begin
			@(posedge clock);
			if (awReady === 1'b1) awValid <= 1'b0;
			if (wReady === 1'b1) wValid <= 1'b0;
		end
		resp = bResp;
		bReady <= 1'b0;
		if (k == 50) hang();
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge clock);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (k = 0; k < 50 && rValid !== 1'b1; k++) begin
			@(posedge clock);
			if (arReady === 1'b1) arValid <= 1'b0;
		end
		rv = rData;
		resp = rResp;
		rReady <= 1'b0;
		if (k == 50) hang();
	endtask
	function automatic logic [15:0] frame(input logic [8:0] d, input int n, input logic [1:0] p);
		logic [15:0] f;
		int i;
		f = '1;
		f[0] = 1'b0;
		for (i = 0; i < n; i++) f[i+1] = d[i];
		if (p[1]) f[n+1] = (^(d & ((9'h1 << n) - 9'h1))) ^ p[0];
		return f;
	endfunction
	task automatic reg_case();
		rd(ubf_pkg::ADDR_CTRL);
		check("ctrlReset", rv, 32'h180);
		rd(ubf_pkg::ADDR_DIV_LOW);
		check("divReset", rv, 32'h0);
		wr(ubf_pkg::ADDR_DIV_HIGH, 32'hff);
		check("wrResp", 32'(resp), 32'h0);
		wr(8'h20, 32'h1);
		check("unmappedWrResp", 32'(resp), 32'h2);
		rd(ubf_pkg::ADDR_DIV_HIGH);
		check("divHigh", rv, 32'h0f);
		wr(ubf_pkg::ADDR_DIV_LOW, 32'hbc);
		rd(ubf_pkg::ADDR_DIV_LOW);
		check("divLow", rv, 32'hbc);
		rd(8'h20);
		check("unmappedResp", 32'(resp), 32'h2);
		check("unmappedData", rv, 32'h0);
		wr(ubf_pkg::ADDR_DIV_HIGH, 32'h0);
		wr(ubf_pkg::ADDR_DIV_LOW, 32'h1);
	endtask
	task automatic tx_case(input logic [31:0] c, input logic [8:0] d, input int n,
		input logic [1:0] p, input logic two, input int bitClk);
		// format set while idle, before data
		wr(ubf_pkg::ADDR_CTRL, c);
		wr(ubf_pkg::ADDR_TX_DATA, 32'(d));
		peer.rx_frame(bitClk, 4 + n + int'(p[1]) + int'(two), bits, lost);
		if (lost) hang();
		check("txFrame", 32'(bits), 32'(frame(d, n, p)));
	endtask
	task automatic rx_case(input logic [31:0] c, input logic [8:0] d, input int n,
		input logic [1:0] p, input logic two, input int bitClk, input int badAt, input logic fe);
		logic [15:0] f;
		f = frame(d, n, p);
		f[badAt] = 1'b0;
		wr(ubf_pkg::ADDR_CTRL, c);
		peer.tx_frame(bitClk, 3 + n + int'(p[1]) + int'(two), f);
		rd(ubf_pkg::ADDR_RX_DATA);
		check("rxData", rv, {21'h0, 1'b0, fe, d});
	endtask
	task automatic sync_case();
		int k;
		int per;
		// double speed kept clear in sync mode
		wr(ubf_pkg::ADDR_CTRL, 32'h183);
		check("masterOe", 32'(xClkOe), 32'h1);
		for (k = 0; k < 100 && xClkOut !== 1'b0; k++) @(posedge clock);
		for (k = 0; k < 100 && xClkOut !== 1'b1; k++) @(posedge clock);
		for (k = 0; k < 100 && xClkOut !== 1'b0; k++) @(posedge clock);
		per = k;
		for (k = 0; k < 100 && xClkOut !== 1'b1; k++) @(posedge clock);
		per = per + k;
		// Divisor 1 gives a tick every 2 clocks, a toggle per tick
		check("masterPeriod", 32'(per), 32'h4);
		wr(ubf_pkg::ADDR_CTRL, 32'h180);
		check("asyncOe", 32'(xClkOe), 32'h0);
	endtask
	task automatic slave_case();
		int k;
		logic [15:0] got;
		wr(ubf_pkg::ADDR_CTRL, 32'h401);
		check("slaveOe", 32'(xClkOe), 32'h0);
		wr(ubf_pkg::ADDR_TX_DATA, 32'h15);
		got = '1;
		for (k = 0; k < 8; k++) begin
			got[k] = txLine;
			// slave clock far below a quarter of system clock
			xClkIn <= 1'b1;
			repeat (8) @(posedge clock);
			xClkIn <= 1'b0;
			repeat (8) @(posedge clock);
		end
		check("slaveFrame", 32'(got), 32'(frame(9'h15, 5, 2'h0)));
	endtask
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		reg_case();
		tx_case(32'hdc0, 9'h0a7, 8, 2'h2, 1'b0, 32);
		tx_case(32'hff4, 9'h1c3, 9, 2'h3, 1'b1, 16);
		rx_case(32'hdc0, 9'h03c, 8, 2'h2, 1'b0, 32, 10, 1'b1);
		rx_case(32'hff4, 9'h155, 9, 2'h3, 1'b1, 16, 12, 1'b0);
		sync_case();
		slave_case();
		complete_run();
	end
endmodule
`default_nettype wire
